//--- rtl/avg_cfg_pkg.sv
// Purpose: shared constants for the averager and its holding-register bank
// Assumes: 16-bit holding registers addressed by register number
// Notes: registers numbered as the map prints them; no byte addressing

package avg_cfg_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_AVG_TIME = 16'h0fa0;
  localparam logic [15:0] REG_OUT_MODE = 16'h0fa1;
  localparam logic [15:0] REG_OVF_EN = 16'h0fa2;
  localparam logic [15:0] REG_STATION = 16'h0fa3;
  localparam logic [15:0] REG_FRAME = 16'h0fa4;
  localparam logic [15:0] REG_BAUD = 16'h0fa5;
  localparam logic [15:0] REG_APPLY = 16'h0fa6;
  localparam logic [15:0] REG_STATUS = 16'h0fa7;
  localparam logic [15:0] REG_RSVD_A = 16'h0fa8;
  localparam logic [15:0] REG_RSVD_B = 16'h0fa9;
  localparam logic [15:0] REG_RSVD_C = 16'h0faa;
  localparam logic [15:0] REG_FW_VER = 16'h0fab;

  // ----------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] AVG_TIME_MAX = 16'h000c;
  localparam logic [15:0] OUT_MODE_MAX = 16'h0002;
  localparam logic [15:0] OVF_EN_MAX = 16'h0001;
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h00f7;
  localparam logic [15:0] FRAME_MAX = 16'h0003;
  localparam logic [15:0] BAUD_MAX = 16'h0002;
  localparam logic [15:0] AVG_TIME_RST = 16'h0001;
  localparam logic [15:0] OUT_MODE_RST = 16'h0000;
  localparam logic [15:0] OVF_EN_RST = 16'h0000;
  localparam logic [15:0] STATION_RST = 16'h0001;
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int ST_UNCAL_BIT = 15;
  localparam int ST_PARAM_BIT = 14;
  localparam int ST_OVF_BIT = 13;
  localparam int ST_FILL_BIT = 12;

  // ----------------------------------------------------------------
  // Timing at 20 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int WR_FLASH_MS = 100;
  localparam int WR_FLASH_CYC = CLK_HZ / 1000 * WR_FLASH_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int MAX_WIN = 100;

  // Output mode codes
  localparam logic [1:0] OMODE_TRACK = 2'h0;
  localparam logic [1:0] OMODE_LOW = 2'h1;
  localparam logic [1:0] OMODE_HIGH = 2'h2;

  typedef enum logic [2:0] {
    LED_INIT = 3'b001,
    LED_RUN = 3'b010,
    LED_FLASH = 3'b100
  } led_state_t;

endpackage

//--- rtl/measurement_averager_config_regs.sv
// Purpose: sliding-window measurement averager with holding-register bank
// Assumes: samples arrive as one-cycle strobes at the refresh period
// Notes: serial framing lives outside; this block sees decoded register writes

`timescale 1ns/1ps

module measurement_averager_config_regs #(
  parameter int SAMPLE_W = 16,
  parameter int WR_FLASH_CYCLES = avg_cfg_pkg::WR_FLASH_CYC,
  parameter int BLINK_CYCLES = avg_cfg_pkg::BLINK_CYC,
  parameter logic [15:0] FW_VERSION = 16'h0100 // Arbitrary version value
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [15:0] i_rd_addr,
  output logic [15:0] o_rd_data,
  output logic o_wr_ack,
  input wire logic i_init_done,
  input wire logic i_uncal,
  input wire logic i_param_err,
  input wire logic i_nvm_err,
  input wire logic i_rx_active,
  input wire logic i_tx_active,
  input wire logic i_sample_vld,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic i_sample_oor,
  input wire logic signed [SAMPLE_W-1:0] i_in_low,
  input wire logic signed [SAMPLE_W-1:0] i_in_high,
  input wire logic signed [SAMPLE_W-1:0] i_sub_low,
  input wire logic signed [SAMPLE_W-1:0] i_sub_high,
  input wire logic signed [SAMPLE_W-1:0] i_out_low,
  input wire logic signed [SAMPLE_W-1:0] i_out_high,
  output logic signed [SAMPLE_W-1:0] o_avg,
  output logic signed [SAMPLE_W-1:0] o_out_value,
  output logic o_avg_vld,
  output logic [3:0] o_sample_period,
  output logic [7:0] o_station_addr,
  output logic [1:0] o_frame_sel,
  output logic [1:0] o_baud_sel,
  output logic o_link_update,
  output logic o_led_red,
  output logic o_led_green,
  output logic o_led_rx,
  output logic o_led_tx
);
  import avg_cfg_pkg::*;

  localparam int SUM_W = SAMPLE_W + 7;
  localparam int FLASH_W = $clog2(WR_FLASH_CYCLES + 1);
  localparam int BLINK_W = $clog2(BLINK_CYCLES + 1);

  initial begin
    if (SAMPLE_W < 8 || SAMPLE_W > 32 || WR_FLASH_CYCLES < 1 || BLINK_CYCLES < 1) begin
      $error("measurement_averager_config_regs: unsupported parameter value");
    end
  end

  // ----------------------------------------------------------------
  // Window length per averaging code
  // ----------------------------------------------------------------
  // samples per window
  function automatic logic [6:0] win_len(input logic [3:0] code);
    case (code)
      4'h0: win_len = 7'h01;
      4'h1: win_len = 7'h02;
      4'h2: win_len = 7'h06;
      4'h3: win_len = 7'h0a;
      4'h4: win_len = 7'h14;
      4'h5: win_len = 7'h1e;
      4'h6: win_len = 7'h3c;
      default: win_len = 7'h64;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pins_async;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, pin_r;
  assign pins_async = {i_init_done, i_uncal, i_param_err, i_nvm_err, i_rx_active, i_tx_active};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          pin_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pins_async[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            pin_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  wire init_done_s = pin_r[5];
  wire uncal_s = pin_r[4];
  wire param_err_s = pin_r[3];
  wire nvm_err_s = pin_r[2];
  wire rx_s = pin_r[1];
  wire tx_s = pin_r[0];

  // ----------------------------------------------------------------
  // Write decode and range checks
  // ----------------------------------------------------------------
  logic [15:0] avg_time_r, out_mode_r, ovf_en_r, station_r, frame_r, baud_r;

  wire ok_avg = i_wr_data <= AVG_TIME_MAX;
  wire ok_mode = i_wr_data <= OUT_MODE_MAX;
  wire ok_ovf = i_wr_data <= OVF_EN_MAX;
  wire ok_sta = (i_wr_data >= STATION_MIN) && (i_wr_data <= STATION_MAX);
  wire ok_frm = i_wr_data <= FRAME_MAX;
  wire ok_bd = i_wr_data <= BAUD_MAX;
  wire ok_apply = i_wr_data <= 16'h0001;

  wire wr_avg = i_wr_en && (i_wr_addr == REG_AVG_TIME) && ok_avg;
  wire wr_mode = i_wr_en && (i_wr_addr == REG_OUT_MODE) && ok_mode;
  wire wr_ovf = i_wr_en && (i_wr_addr == REG_OVF_EN) && ok_ovf;
  wire wr_sta = i_wr_en && (i_wr_addr == REG_STATION) && ok_sta;
  wire wr_frm = i_wr_en && (i_wr_addr == REG_FRAME) && ok_frm;
  wire wr_bd = i_wr_en && (i_wr_addr == REG_BAUD) && ok_bd;
  wire wr_apply = i_wr_en && (i_wr_addr == REG_APPLY) && ok_apply;
  wire wr_accept = wr_avg | wr_mode | wr_ovf | wr_sta | wr_frm | wr_bd | wr_apply;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      avg_time_r <= AVG_TIME_RST;
      out_mode_r <= OUT_MODE_RST;
      ovf_en_r <= OVF_EN_RST;
      station_r <= STATION_RST;
      frame_r <= FRAME_RST;
      baud_r <= BAUD_RST;
    end else begin
      if (wr_avg) avg_time_r <= i_wr_data;
      if (wr_mode) out_mode_r <= i_wr_data;
      if (wr_ovf) ovf_en_r <= i_wr_data;
      if (wr_sta) station_r <= i_wr_data;
      if (wr_frm) frame_r <= i_wr_data;
      if (wr_bd) baud_r <= i_wr_data;
    end
  end

  // Link settings only move on apply, so a half-typed change never breaks the link
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_station_addr <= STATION_RST[7:0];
      o_frame_sel <= FRAME_RST[1:0];
      o_baud_sel <= BAUD_RST[1:0];
      o_link_update <= 1'b0;
      o_wr_ack <= 1'b0;
    end else begin
      o_link_update <= wr_apply && i_wr_data[0];
      if (wr_apply && i_wr_data[0]) begin
        o_station_addr <= station_r[7:0];
        o_frame_sel <= frame_r[1:0];
        o_baud_sel <= baud_r[1:0];
      end
      o_wr_ack <= wr_accept;
    end
  end

  // ----------------------------------------------------------------
  // Sliding window averager
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0] win_mem [MAX_WIN];
  logic [6:0] wptr_r, count_r;
  logic signed [SUM_W-1:0] sum_r;
  logic ovf_r;
  logic [3:0] code_r;

  wire [6:0] win = win_len(avg_time_r[3:0]);
  wire code_chg = code_r != avg_time_r[3:0];
  wire full = count_r >= win;
  wire [6:0] oldest_idx = (wptr_r >= win) ? 7'(wptr_r - win) : 7'(wptr_r + 7'(MAX_WIN) - win);
  wire signed [SUM_W-1:0] old_ext = SUM_W'(win_mem[oldest_idx]);
  wire signed [SUM_W-1:0] new_ext = SUM_W'(i_sample);
  wire signed [SUM_W-1:0] sum_nxt = full ? (sum_r + new_ext - old_ext) : (sum_r + new_ext);
  wire [6:0] count_nxt = full ? count_r : 7'(count_r + 7'h01);
  wire [6:0] wptr_nxt = (wptr_r == 7'(MAX_WIN - 1)) ? 7'h00 : 7'(wptr_r + 7'h01);
  // mean over the last win samples, or over the samples gathered so far while the window fills
  wire signed [SUM_W-1:0] mean = sum_nxt / $signed({1'b0, count_nxt});

  always_ff @(posedge i_sys_clk) begin
    if (i_sample_vld && !i_sample_oor) begin
      win_mem[wptr_r] <= i_sample;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wptr_r <= 7'h00;
      count_r <= 7'h00;
      sum_r <= '0;
      ovf_r <= 1'b0;
      code_r <= AVG_TIME_RST[3:0];
      o_avg <= '0;
      o_avg_vld <= 1'b0;
    end else begin
      code_r <= avg_time_r[3:0];
      o_avg_vld <= 1'b0;
      if (code_chg) begin
        count_r <= 7'h00;
        sum_r <= '0;
      end else if (i_sample_vld) begin
        if (i_sample_oor) begin
          ovf_r <= 1'b1;
          count_r <= 7'h00;
          sum_r <= '0;
        end else begin
          ovf_r <= 1'b0;
          count_r <= count_nxt;
          sum_r <= sum_nxt;
          wptr_r <= wptr_nxt;
          o_avg <= SAMPLE_W'(mean);
          o_avg_vld <= 1'b1;
        end
      end
    end
  end

  // refresh period code to sample pacer
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample_period <= 4'h0;
    end else begin
      o_sample_period <= (avg_time_r[3:0] <= 4'h6) ? 4'h0 : 4'(avg_time_r[3:0] - 4'h6);
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  // limit substitution when enabled
  wire below = o_avg <= i_in_low;
  wire above = o_avg >= i_in_high;
  wire signed [SAMPLE_W-1:0] tracked = (ovf_en_r[0] && below) ? i_sub_low :
                                       (ovf_en_r[0] && above) ? i_sub_high : o_avg;
  wire signed [SAMPLE_W-1:0] out_sel = (out_mode_r[1:0] == OMODE_LOW) ? i_out_low :
                                       (out_mode_r[1:0] == OMODE_HIGH) ? i_out_high : tracked;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out_value <= '0;
    end else begin
      o_out_value <= out_sel;
    end
  end

  // ----------------------------------------------------------------
  // Status word and readback
  // ----------------------------------------------------------------
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[ST_UNCAL_BIT] = uncal_s;
    status[ST_PARAM_BIT] = param_err_s;
    status[ST_OVF_BIT] = ovf_r;
    status[ST_FILL_BIT] = !full;
  end

  wire [15:0] rd_mux = (i_rd_addr == REG_AVG_TIME) ? avg_time_r :
                       (i_rd_addr == REG_OUT_MODE) ? out_mode_r :
                       (i_rd_addr == REG_OVF_EN) ? ovf_en_r :
                       (i_rd_addr == REG_STATION) ? station_r :
                       (i_rd_addr == REG_FRAME) ? frame_r :
                       (i_rd_addr == REG_BAUD) ? baud_r :
                       (i_rd_addr == REG_STATUS) ? status :
                       (i_rd_addr == REG_FW_VER) ? FW_VERSION : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  led_state_t led_r;
  logic [FLASH_W-1:0] flash_r;
  logic [BLINK_W-1:0] blink_cnt_r;
  logic blink_r;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      led_r <= LED_INIT;
      flash_r <= '0;
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else begin
      if (wr_accept) flash_r <= FLASH_W'(WR_FLASH_CYCLES);
      else if (flash_r != '0) flash_r <= flash_r - 1'b1;
      if (blink_cnt_r == BLINK_W'(BLINK_CYCLES - 1)) begin
        blink_cnt_r <= '0;
        blink_r <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 1'b1;
      end
      case (led_r)
        LED_INIT: if (init_done_s) led_r <= (uncal_s || nvm_err_s) ? LED_FLASH : LED_RUN;
        LED_RUN: if (uncal_s || nvm_err_s) led_r <= LED_FLASH;
        LED_FLASH: if (!uncal_s && !nvm_err_s) led_r <= LED_RUN;
        default: led_r <= LED_INIT;
      endcase
    end
  end

  wire red_nxt = (led_r == LED_INIT) || (led_r == LED_FLASH && blink_r) ||
                 (led_r == LED_RUN && param_err_s) || (flash_r != '0);
  wire green_nxt = (led_r == LED_RUN) && !param_err_s && (flash_r == '0);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_led_red <= 1'b1;
      o_led_green <= 1'b0;
      o_led_rx <= 1'b0;
      o_led_tx <= 1'b0;
    end else begin
      o_led_red <= red_nxt;
      o_led_green <= green_nxt;
      o_led_rx <= rx_s;
      o_led_tx <= tx_s;
    end
  end

endmodule

//--- test/avg_cfg_asserts.sv
// Purpose: port checks for the averager register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to the top module by the bind below
`timescale 1ns/1ps
module avg_cfg_asserts (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic [15:0] i_rd_addr,
  input wire logic [15:0] o_rd_data,
  input wire logic o_wr_ack,
  input wire logic i_sample_vld,
  input wire logic i_sample_oor,
  input wire logic o_avg_vld,
  input wire logic o_link_update,
  input wire logic o_led_red
);
  import avg_cfg_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // ------------------------------------------------------------
  // Write acceptance
  // ------------------------------------------------------------
  sequence wr_avg_s;
    i_wr_en && i_wr_addr == REG_AVG_TIME;
  endsequence
  sequence ack_flash_s;
    o_wr_ack ##1 o_led_red;
  endsequence
  a_avg_wr_ack: assert property (wr_avg_s ##0 i_wr_data <= AVG_TIME_MAX |=> ack_flash_s)
    else $error("in-range averaging write not acknowledged");
  a_avg_wr_refuse: assert property (wr_avg_s ##0 i_wr_data > AVG_TIME_MAX |=> !o_wr_ack)
    else $error("out-of-range averaging write acknowledged");
  a_idle_no_ack: assert property (!i_wr_en |=> !o_wr_ack)
    else $error("acknowledge without a write");
  a_station_zero: assert property (i_wr_en && i_wr_addr == REG_STATION && i_wr_data == 16'h0000
    |=> !o_wr_ack) else $error("station address zero accepted");
  a_apply_pulse: assert property (i_wr_en && i_wr_addr == REG_APPLY && i_wr_data == 16'h0001
    |=> o_link_update) else $error("apply write gave no link update");
  a_no_apply: assert property (!i_wr_en |=> !o_link_update)
    else $error("link update without a write");
  // ------------------------------------------------------------
  // Samples and readback
  // ------------------------------------------------------------
  a_oor_no_mean: assert property (i_sample_vld && i_sample_oor |=> !o_avg_vld)
    else $error("mean refreshed by an out-of-range sample");
  a_mean_refresh: assert property (i_sample_vld && !i_sample_oor && !i_wr_en &&
    !$past(i_wr_en) |=> o_avg_vld) else $error("valid sample gave no mean");
  a_rsvd_zero: assert property (i_rd_addr == REG_RSVD_A |=> o_rd_data == 16'h0000)
    else $error("reserved word reads non-zero");
endmodule

bind measurement_averager_config_regs avg_cfg_asserts chk_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
  .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_wr_ack(o_wr_ack),
  .i_sample_vld(i_sample_vld), .i_sample_oor(i_sample_oor), .o_avg_vld(o_avg_vld),
  .o_link_update(o_link_update), .o_led_red(o_led_red)
);

//--- test/modbus_master_model.sv
// Purpose: serial-line master issuing decoded holding-register writes
// Assumes: one write strobe of one cycle per request
// Notes: address and data are scrambled outside the strobe
`timescale 1ns/1ps
module modbus_master_model (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic [15:0] o_wr_addr,
  output logic [15:0] o_wr_data
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 16'h0000;
    o_wr_data = 16'h0000;
  end
  // settings and apply arrive as register writes
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask
endmodule

//--- test/tb_measurement_averager_config_regs.sv
// Purpose: self-checking bench for the averager register bank
// Assumes: 20 MHz clock; writes come from the master model
// Notes: flash and blink counts cut to 4 cycles to keep the run short
`timescale 1ns/1ps
module tb_measurement_averager_config_regs;
  import avg_cfg_pkg::*;
  // Arbitrary version value
  localparam logic [15:0] FW = 16'h0a5c;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wr_en;
  logic [15:0] i_wr_addr, i_wr_data, o_rd_data;
  logic [15:0] i_rd_addr = 16'h0000;
  logic i_init_done = 1'b0, i_uncal = 1'b0, i_param_err = 1'b0, i_nvm_err = 1'b0;
  logic i_rx_active = 1'b0, i_tx_active = 1'b0, i_sample_vld = 1'b0, i_sample_oor = 1'b0;
  logic signed [15:0] i_sample = 16'h0000, i_in_low = 16'hff9c, i_in_high = 16'h03e8;
  logic signed [15:0] i_sub_low = 16'hfff9, i_sub_high = 16'h0309;
  logic signed [15:0] i_out_low = 16'h000b, i_out_high = 16'h0016, o_avg, o_out_value;
  logic o_wr_ack, o_avg_vld, o_link_update, o_led_red, o_led_green, o_led_rx, o_led_tx;
  logic [3:0] o_sample_period;
  logic [7:0] o_station_addr;
  logic [1:0] o_frame_sel, o_baud_sel;
  int n_errors = 0, n_compared = 0, cyc = 0;
  // Write table: address, data, readback after; bit i of wk marks an accepted write
  logic [15:0] wa[16] = '{REG_AVG_TIME, REG_AVG_TIME, REG_OUT_MODE, REG_OUT_MODE, REG_OVF_EN,
    REG_OVF_EN, REG_STATION, REG_STATION, REG_STATION, REG_FRAME, REG_FRAME, REG_BAUD,
    REG_BAUD, REG_FW_VER, REG_RSVD_B, 16'h0fac};
  logic [15:0] wd[16] = '{16'h000c, 16'h000d, 16'h0002, 16'h0003, 16'h0001, 16'h0002,
    16'h0000, 16'h00f8, 16'h00f7, 16'h0003, 16'h0004, 16'h0002, 16'h0003, 16'h0005,
    16'h0005, 16'h0007};
  logic [15:0] we[16] = '{16'h000c, 16'h000c, 16'h0002, 16'h0002, 16'h0001, 16'h0001,
    16'h0001, 16'h0001, 16'h00f7, 16'h0003, 16'h0003, 16'h0002, 16'h0002, FW, 16'h0000,
    16'h0000};
  logic [15:0] wk = 16'h0b15;
  logic [15:0] ra[9] = '{REG_AVG_TIME, REG_OUT_MODE, REG_OVF_EN, REG_STATION, REG_FRAME,
    REG_BAUD, REG_APPLY, REG_RSVD_A, REG_FW_VER};
  logic [15:0] rv[9] = '{16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, FW};
  int wl[8] = '{1, 2, 6, 10, 20, 30, 60, 100};

  measurement_averager_config_regs #(.SAMPLE_W(16), .WR_FLASH_CYCLES(4), .BLINK_CYCLES(4),
    .FW_VERSION(FW)) measurement_averager_config_regs_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
    .o_wr_ack(o_wr_ack), .i_init_done(i_init_done), .i_uncal(i_uncal),
    .i_param_err(i_param_err), .i_nvm_err(i_nvm_err), .i_rx_active(i_rx_active),
    .i_tx_active(i_tx_active), .i_sample_vld(i_sample_vld), .i_sample(i_sample),
    .i_sample_oor(i_sample_oor), .i_in_low(i_in_low), .i_in_high(i_in_high),
    .i_sub_low(i_sub_low), .i_sub_high(i_sub_high), .i_out_low(i_out_low),
    .i_out_high(i_out_high), .o_avg(o_avg), .o_out_value(o_out_value),
    .o_avg_vld(o_avg_vld), .o_sample_period(o_sample_period),
    .o_station_addr(o_station_addr), .o_frame_sel(o_frame_sel), .o_baud_sel(o_baud_sel),
    .o_link_update(o_link_update), .o_led_red(o_led_red), .o_led_green(o_led_green),
    .o_led_rx(o_led_rx), .o_led_tx(o_led_tx));
  modbus_master_model modbus_master_model_inst (.i_clk(i_sys_clk), .o_wr_en(i_wr_en),
    .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data));

  always #25 i_sys_clk = ~i_sys_clk;
  // Whole run needs about 1100 cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic k);
    modbus_master_model_inst.write(a, d);
    chk("write ack", 16'(o_wr_ack), 16'(k));
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    nx(1);
    i_rd_addr = a;
    nx(1);
    v = o_rd_data;
  endtask
  task automatic put(input logic [15:0] x, input logic oor);
    nx(1);
    i_sample_vld = 1'b1;
    i_sample = x;
    i_sample_oor = oor;
    nx(1);
    i_sample_vld = 1'b0;
    i_sample_oor = 1'b0;
    nx(1);
  endtask
  task automatic seen(input logic [15:0] e, input logic [3:0] f);
    logic [15:0] v;
    chk("mean", o_avg, e);
    rd(REG_STATUS, v);
    chk("status flags", 16'(v[15:12]), 16'(f));
  endtask
  task automatic outv(input logic [15:0] m, input logic [15:0] x, input logic [15:0] e);
    wr(REG_OUT_MODE, m, 1'b1);
    put(x, 1'b0);
    chk("output", o_out_value, e);
  endtask
  task automatic reds(output int h);
    h = 0;
    repeat (24) begin
      nx(1);
      h += int'(o_led_red);
    end
  endtask
  task automatic pins(input logic [4:0] p);
    {i_uncal, i_param_err, i_nvm_err, i_rx_active, i_tx_active} = p;
    nx(6);
  endtask
  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] v;
    chk("red at init", 16'(o_led_red), 16'h0001);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], v);
      chk("reset value", v, rv[i]);
    end
    seen(16'h0000, 4'h1);
    i_init_done = 1'b1;
    nx(6);
    chk("green after init", 16'({o_led_red, o_led_green}), 16'h0001);
  endtask
  task automatic t_ranges;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      wr(wa[i], wd[i], wk[i]);
      rd(wa[i], v);
      chk("stored", v, we[i]);
    end
  endtask
  task automatic t_apply;
    logic [15:0] v;
    int h;
    wr(REG_APPLY, 16'h0000, 1'b1);
    chk("no update", 16'({o_link_update, o_station_addr}), 16'h0001);
    reds(h);
    chk("write flash", 16'(h), 16'h0004);
    wr(REG_APPLY, 16'h0001, 1'b1);
    chk("update", 16'(o_link_update), 16'h0001);
    nx(1);
    chk("address", 16'(o_station_addr), 16'h00f7);
    for (int f = 0; f < 4; f++) begin
      wr(REG_FRAME, 16'(f), 1'b1);
      wr(REG_BAUD, 16'(f % 3), 1'b1);
      wr(REG_APPLY, 16'h0001, 1'b1);
      nx(1);
      chk("framing and rate", 16'({o_frame_sel, o_baud_sel}), 16'(f * 4 + f % 3));
    end
    rd(REG_APPLY, v);
    chk("apply reads", v, 16'h0000);
  endtask
  task automatic t_avg;
    for (int c = 0; c < 13; c++) begin
      wr(REG_AVG_TIME, 16'(c), 1'b1);
      nx(1);
      chk("period", 16'(o_sample_period), 16'(c < 7 ? 0 : c - 6));
    end
    wr(REG_OUT_MODE, 16'h0000, 1'b1);
    wr(REG_OVF_EN, 16'h0000, 1'b1);
    wr(REG_AVG_TIME, 16'h0001, 1'b1);
    put(16'h0064, 1'b0);
    seen(16'h0064, 4'h1);
    put(16'h00c8, 1'b0);
    seen(16'h0096, 4'h0);
    put(16'h0190, 1'b0);
    seen(16'h012c, 4'h0);
    put(16'h0000, 1'b1);
    seen(16'h012c, 4'h3);
    put(16'h0032, 1'b0);
    seen(16'h0032, 4'h1);
    wr(REG_AVG_TIME, 16'h0002, 1'b1);
    for (int i = 1; i < 7; i++) begin
      put(16'(12 * i), 1'b0);
      seen(16'(6 * (i + 1)), 4'(i < 6));
    end
    for (int c = 3; c < 8; c++) begin
      wr(REG_AVG_TIME, 16'(c), 1'b1);
      repeat (wl[c] - 1) put(16'h0010, 1'b0);
      seen(16'h0010, 4'h1);
      put(16'h0010, 1'b0);
      seen(16'h0010, 4'h0);
    end
  endtask
  task automatic t_rerst;
    logic [15:0] v;
    i_resetn = 1'b0;
    nx(2);
    i_resetn = 1'b1;
    chk("red after reset", 16'({o_led_red, o_led_green}), 16'h0002);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], v);
      chk("reset again", v, rv[i]);
    end
    seen(16'h0000, 4'h1);
    chk("link after reset", 16'({o_station_addr, o_frame_sel, o_baud_sel}), 16'h0010);
  endtask
  task automatic t_out;
    wr(REG_AVG_TIME, 16'h0000, 1'b1);
    outv(16'h0000, 16'h07d0, 16'h07d0);
    wr(REG_OVF_EN, 16'h0001, 1'b1);
    outv(16'h0000, 16'h07d0, 16'h0309);
    outv(16'h0000, 16'h03e8, 16'h0309);
    outv(16'h0000, 16'hff38, 16'hfff9);
    outv(16'h0000, 16'h01f4, 16'h01f4);
    outv(16'h0001, 16'h01f4, 16'h000b);
    outv(16'h0002, 16'h01f4, 16'h0016);
  endtask
  task automatic t_leds;
    logic [15:0] v;
    int h;
    pins(5'b10000);
    rd(REG_STATUS, v);
    chk("uncal flag", 16'(v[15:14]), 16'h0002);
    reds(h);
    chk("blink", 16'(h > 0 && h < 24), 16'h0001);
    pins(5'b01000);
    rd(REG_STATUS, v);
    chk("param flag", 16'(v[15:14]), 16'h0001);
    reds(h);
    chk("steady", 16'(h), 16'h0018);
    pins(5'b00100);
    reds(h);
    chk("blink", 16'(h > 0 && h < 24), 16'h0001);
    pins(5'b00010);
    chk("receive", 16'({o_led_rx, o_led_tx}), 16'h0002);
    pins(5'b00001);
    chk("transmit", 16'({o_led_rx, o_led_tx}), 16'h0001);
  endtask

  initial begin
    repeat (12) @(posedge i_sys_clk);
    nx(1);
    i_resetn = 1'b1;
    t_reset();
    t_ranges();
    t_apply();
    t_avg();
    t_out();
    t_rerst();
    t_leds();
    conclude();
  end
endmodule
